// ### rtl/vphy_map.svh
// register offsets, field positions and reset values of the virtual phy
// identification and advertisement registers.
// assumes byte addresses on the internal map, one 32-bit word each.
`ifndef VPHY_MAP_SVH
`define VPHY_MAP_SVH

// ----------------------------------------------------------------------
// internal map byte offsets
// ----------------------------------------------------------------------
`define VPHY_OFS_ID_HIGH    9'h1c8
`define VPHY_OFS_ID_LOW     9'h1cc
`define VPHY_OFS_ADV        9'h1d0
`define VPHY_OFS_MIN_W      9

// ----------------------------------------------------------------------
// management register numbers
// ----------------------------------------------------------------------
`define VPHY_MII_ID_HIGH    5'h02
`define VPHY_MII_ID_LOW     5'h03
`define VPHY_MII_ADV        5'h04

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define VPHY_BIT_ASYM       11
`define VPHY_BIT_PAUSE      10
`define VPHY_HALF_W         16

// ----------------------------------------------------------------------
// reset values and host-writable masks
// ----------------------------------------------------------------------
`define VPHY_RST_ID_HIGH    16'h0000
`define VPHY_RST_ID_LOW     16'h0000
`define VPHY_RST_ADV        16'h01e1
`define VPHY_WMASK_ID       16'hffff
`define VPHY_WMASK_ADV      16'h0dff
`define VPHY_RSVD_HIGH      16'h0000

`endif

// ### rtl/vphy_pkg.sv
// types shared by the virtual phy register bank.
// assumes nothing beyond a systemverilog compiler.
package vphy_pkg;

	// one management-visible register half
	typedef logic [15:0] vphy_half_t;

	// strap capture sequence after reset release
	typedef enum logic [1:0] {
		STRAP_FILL,
		STRAP_LAST,
		STRAP_APPLY,
		STRAP_DONE
	} vphy_strap_e;

endpackage

// ### rtl/vphy_regs.sv
// virtual phy identification and advertisement register bank.
// assumes a word-wide internal map port, a register-level management
// port (frame decoding lives outside) and a configuration loader.
//
// What this block does
// - id low bits 15:10 hold oui, rw, zero
// - id low bits 9:4 model number, rw, zero
// - id low bits 3:0 revision, rw, zero
// - 32-bit words, upper half reads zero; mii 16
// - advertisement at 1d0 and mii register four
// - next page bit 15 reads zero always
// - remote fault bit 13 reads zero always
// - asymmetric pause bit 11 rw, reset zero
// - pause bit resets to inverted latched strap
// - t4 ability bit 9 reads zero always
// - bits 8 to 5 rw abilities, reset one
// - selector 4:0 rw, resets to 00001
// - loader overwrites every writable advertisement bit
// - partner asym pause follows bit 11, sym pause is bit 10 xor bit 11
// - id high word below low, rw, zero
`timescale 1ns/100ps
`include "vphy_map.svh"
module vphy_regs #(
	parameter int ADDR_W = 9   // internal map byte address width
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// configuration strap pin
	input  wire logic              manual_flow_ctl_strap,
	// internal map port
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic              bus_wr,
	input  wire logic              bus_rd,
	input  wire logic [31:0]       bus_wdata,
	output logic      [31:0]       bus_rdata,
	output logic                   bus_rvalid,
	// management register port
	input  wire logic [4:0]        mii_reg,
	input  wire logic              mii_wr,
	input  wire logic              mii_rd,
	input  wire logic [15:0]       mii_wdata,
	output logic      [15:0]       mii_rdata,
	output logic                   mii_rvalid,
	// configuration loader
	input  wire logic              load_valid,
	input  wire logic [15:0]       load_data,
	// to the auto-negotiation emulation
	output logic      [15:0]       adv_word,
	output logic                   lp_pause_sym,
	output logic                   lp_pause_asym
);

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	if (ADDR_W < `VPHY_OFS_MIN_W) begin : g_addr_chk
		$error("ADDR_W too narrow for the register offsets");
	end

	// ------------------------------------------------------------------
	// strap synchroniser and capture
	// ------------------------------------------------------------------
	logic               strap_meta_reg;   // first stage, read by sync only
	logic               strap_sync_reg;   // second stage
	vphy_pkg::vphy_strap_e strap_st_reg;  // capture progress
	vphy_pkg::vphy_strap_e strap_st_next;

	// waits two edges so the synchroniser holds the pin level
	always_comb begin
		strap_st_next = strap_st_reg;
		case (strap_st_reg)
			vphy_pkg::STRAP_FILL:  strap_st_next = vphy_pkg::STRAP_LAST;
			vphy_pkg::STRAP_LAST:  strap_st_next = vphy_pkg::STRAP_APPLY;
			vphy_pkg::STRAP_APPLY: strap_st_next = vphy_pkg::STRAP_DONE;
			vphy_pkg::STRAP_DONE:  strap_st_next = vphy_pkg::STRAP_DONE;
			default:               strap_st_next = vphy_pkg::STRAP_DONE;
		endcase
	end

	// register stage of the strap path
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_meta_reg <= 1'b0;
			strap_sync_reg <= 1'b0;
			strap_st_reg   <= vphy_pkg::STRAP_FILL;
		end else begin
			strap_meta_reg <= manual_flow_ctl_strap;
			strap_sync_reg <= strap_meta_reg;
			strap_st_reg   <= strap_st_next;
		end
	end

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	logic [ADDR_W-1:0] word_addr;  // byte address with lane bits dropped
	logic bus_hit_hi;              // id high word selected
	logic bus_hit_lo;              // id low word selected
	logic bus_hit_adv;             // advertisement selected
	logic mii_hit_hi;
	logic mii_hit_lo;
	logic mii_hit_adv;

	// lane bits are ignored: every register is one aligned word
	assign word_addr   = {bus_addr[ADDR_W-1:2], 2'b00};
	assign bus_hit_hi  = word_addr == ADDR_W'(`VPHY_OFS_ID_HIGH);
	assign bus_hit_lo  = word_addr == ADDR_W'(`VPHY_OFS_ID_LOW);
	assign bus_hit_adv = word_addr == ADDR_W'(`VPHY_OFS_ADV);
	assign mii_hit_hi  = mii_reg == `VPHY_MII_ID_HIGH;
	assign mii_hit_lo  = mii_reg == `VPHY_MII_ID_LOW;
	assign mii_hit_adv = mii_reg == `VPHY_MII_ADV;

	// ------------------------------------------------------------------
	// write arbitration
	// ------------------------------------------------------------------
	vphy_pkg::vphy_half_t id_hi_q;   // stored id high word
	vphy_pkg::vphy_half_t id_lo_q;   // stored id low word
	vphy_pkg::vphy_half_t adv_q;     // stored advertisement
	logic                 id_hi_we;
	logic                 id_lo_we;
	logic                 adv_we;
	vphy_pkg::vphy_half_t id_hi_wd;
	vphy_pkg::vphy_half_t id_lo_wd;
	vphy_pkg::vphy_half_t adv_wd;

	// bus beats management; loader beats everything on the
	// advertisement so a reload always leaves its image intact
	always_comb begin
		id_hi_we = (bus_wr && bus_hit_hi) || (mii_wr && mii_hit_hi);
		id_hi_wd = (bus_wr && bus_hit_hi) ? bus_wdata[15:0] : mii_wdata;
		id_lo_we = (bus_wr && bus_hit_lo) || (mii_wr && mii_hit_lo);
		id_lo_wd = (bus_wr && bus_hit_lo) ? bus_wdata[15:0] : mii_wdata;
		adv_we   = 1'b0;
		adv_wd   = adv_q;
		if (load_valid) begin
			adv_we = 1'b1;
			adv_wd = load_data;
		end else if (strap_st_reg == vphy_pkg::STRAP_APPLY) begin
			adv_we = 1'b1;
			adv_wd[`VPHY_BIT_PAUSE] = ~strap_sync_reg;
		end else if (bus_wr && bus_hit_adv) begin
			adv_we = 1'b1;
			adv_wd = bus_wdata[15:0];
		end else if (mii_wr && mii_hit_adv) begin
			adv_we = 1'b1;
			adv_wd = mii_wdata;
		end
	end

	// ------------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------------
	// whole word writable, resets to zero
	vphy_word_reg #(
		.RST_VAL (`VPHY_RST_ID_HIGH),
		.WR_MASK (`VPHY_WMASK_ID)
	) u_id_hi (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.we      (id_hi_we),
		.wd      (id_hi_wd),
		.q       (id_hi_q)
	);

	// oui, model and revision fields, all writable, all zero
	vphy_word_reg #(
		.RST_VAL (`VPHY_RST_ID_LOW),
		.WR_MASK (`VPHY_WMASK_ID)
	) u_id_lo (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.we      (id_lo_we),
		.wd      (id_lo_wd),
		.q       (id_lo_q)
	);

	// mask pins bits 15,14,13,12,9 at zero whatever is written
	vphy_word_reg #(
		.RST_VAL (`VPHY_RST_ADV),
		.WR_MASK (`VPHY_WMASK_ADV)
	) u_adv (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.we      (adv_we),
		.wd      (adv_wd),
		.q       (adv_q)
	);

	// ------------------------------------------------------------------
	// read paths and partner emulation
	// ------------------------------------------------------------------
	logic [31:0] bus_rdata_reg;    // held bus read word
	logic [31:0] bus_rdata_next;
	logic        bus_rvalid_reg;   // one-cycle bus read strobe
	logic        bus_rvalid_next;
	logic [15:0] mii_rdata_reg;    // held management read word
	logic [15:0] mii_rdata_next;
	logic        mii_rvalid_reg;   // one-cycle management read strobe
	logic        mii_rvalid_next;
	logic        lp_sym_reg;       // emulated partner symmetric pause
	logic        lp_sym_next;
	logic        lp_asym_reg;      // emulated partner asymmetric pause
	logic        lp_asym_next;

	// read data is held until the next read request; unmapped
	// addresses read as zero and the upper half is always zero
	always_comb begin
		bus_rvalid_next = bus_rd;
		mii_rvalid_next = mii_rd;
		bus_rdata_next  = bus_rdata_reg;
		if (bus_rd) begin
			bus_rdata_next = 32'h0000_0000;
			if (bus_hit_hi) begin
				bus_rdata_next = {`VPHY_RSVD_HIGH, id_hi_q};
			end else if (bus_hit_lo) begin
				bus_rdata_next = {`VPHY_RSVD_HIGH, id_lo_q};
			end else if (bus_hit_adv) begin
				bus_rdata_next = {`VPHY_RSVD_HIGH, adv_q};
			end
		end
		mii_rdata_next = mii_rdata_reg;
		if (mii_rd) begin
			mii_rdata_next = 16'h0000;
			if (mii_hit_hi) begin
				mii_rdata_next = id_hi_q;
			end else if (mii_hit_lo) begin
				mii_rdata_next = id_lo_q;
			end else if (mii_hit_adv) begin
				mii_rdata_next = adv_q;
			end
		end
		// partner grants asymmetric as asked, symmetric only when exactly one pause bit is set
		lp_sym_next  = adv_q[`VPHY_BIT_PAUSE] ^
			adv_q[`VPHY_BIT_ASYM];
		lp_asym_next = adv_q[`VPHY_BIT_ASYM];
	end

	// register stage of the read paths
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata_reg  <= 32'h0000_0000;
			bus_rvalid_reg <= 1'b0;
			mii_rdata_reg  <= 16'h0000;
			mii_rvalid_reg <= 1'b0;
			lp_sym_reg     <= 1'b0;
			lp_asym_reg    <= 1'b0;
		end else begin
			bus_rdata_reg  <= bus_rdata_next;
			bus_rvalid_reg <= bus_rvalid_next;
			mii_rdata_reg  <= mii_rdata_next;
			mii_rvalid_reg <= mii_rvalid_next;
			lp_sym_reg     <= lp_sym_next;
			lp_asym_reg    <= lp_asym_next;
		end
	end

	assign bus_rdata     = bus_rdata_reg;
	assign bus_rvalid    = bus_rvalid_reg;
	assign mii_rdata     = mii_rdata_reg;
	assign mii_rvalid    = mii_rvalid_reg;
	assign adv_word      = adv_q;
	assign lp_pause_sym  = lp_sym_reg;
	assign lp_pause_asym = lp_asym_reg;

endmodule // vphy_regs

// ### rtl/vphy_word_reg.sv
// one 16-bit register with fixed read-only bits.
// assumes the caller has already chosen one write per cycle.
`timescale 1ns/100ps
module vphy_word_reg #(
	parameter logic [15:0] RST_VAL = 16'h0000,  // reset and fixed values
	parameter logic [15:0] WR_MASK = 16'hffff   // bits that take writes
) (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// write request
	input  wire logic        we,
	input  wire logic [15:0] wd,
	// stored value
	output logic      [15:0] q
);

	logic [15:0] q_reg;   // stored word
	logic [15:0] q_next;  // next stored word

	// ------------------------------------------------------------------
	// next value: masked bits never move off their fixed value
	// ------------------------------------------------------------------
	always_comb begin
		q_next = q_reg;
		if (we) begin
			q_next = (wd & WR_MASK) | (RST_VAL & ~WR_MASK);
		end
	end

	// register stage
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= RST_VAL;
		end else begin
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

endmodule // vphy_word_reg

// ### testbench/vphy_host.sv
// host management model: register-level mii requests.
// assumes one mii_op call per falling edge, idle is wr and rd low.
`timescale 1ns/100ps
module vphy_host (
	// clock
	input  wire logic        clk_sys,
	// management request
	output logic      [4:0]  mii_reg,
	output logic             mii_wr,
	output logic             mii_rd,
	output logic      [15:0] mii_wdata
);
	initial begin
		mii_reg = 5'h00;
		mii_wr = 1'b0;
		mii_rd = 1'b0;
		mii_wdata = 16'h0000;
	end
	// drive one request; a released data line shows the inverse
	task automatic mii_op(input logic wr, input logic rd,
		input logic [4:0] rn, input logic [15:0] wd);
		@(negedge clk_sys);
		mii_wr = wr;
		mii_rd = rd;
		mii_reg = rn;
		// software keeps the selector at 802.3 on advertisement writes
		if (!wr) mii_wdata = ~mii_wdata;
		else mii_wdata = (rn == 5'h04) ? {wd[15:5], 5'h01} : wd;
	endtask
endmodule // vphy_host

// ### testbench/vphy_regs_properties.sv
// assertions on the ports of the virtual phy register bank.
// assumes a bind to vphy_regs, one clock, strap steady around reset.
`timescale 1ns/100ps
module vphy_regs_chk #(
	parameter int ADDR_W = 9  // byte address width
) (
	// clock, reset and strap
	input wire logic              clk_sys,
	input wire logic              rst_n,
	input wire logic              manual_flow_ctl_strap,
	// internal map port
	input wire logic [ADDR_W-1:0] bus_addr,
	input wire logic              bus_wr,
	input wire logic              bus_rd,
	input wire logic [31:0]       bus_wdata,
	input wire logic [31:0]       bus_rdata,
	// management port and loader
	input wire logic [4:0]        mii_reg,
	input wire logic              mii_rd,
	input wire logic [15:0]       mii_rdata,
	input wire logic              load_valid,
	input wire logic [15:0]       load_data,
	// advertisement outputs
	input wire logic [15:0]       adv_word,
	input wire logic              lp_pause_sym,
	input wire logic              lp_pause_asym
);
	// ----------------------------------------------
	// checks
	// ----------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// edges since release; held at 4 so the strap window shows once
	logic [2:0] up_reg;
	logic [2:0] up_next;
	always_comb up_next = (up_reg == 3'h4) ? up_reg : up_reg + 3'h1;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) up_reg <= 3'h0;
		else up_reg <= up_next;
	end
	// id low write, then its read on the very next cycle
	sequence id_wr_s;
		bus_wr && !bus_rd && bus_addr == 9'h1cc;
	endsequence
	sequence id_rd_s;
		bus_rd && !bus_wr && bus_addr == 9'h1cc;
	endsequence
	id_back_a: assert property (
		id_wr_s ##1 id_rd_s
		|=> bus_rdata == {16'h0000, $past(bus_wdata[15:0], 2)})
		else $error("id low readback wrong");
	adv_rd_a: assert property (
		bus_rd && bus_addr == 9'h1d0
		|=> bus_rdata == {16'h0000, $past(adv_word)})
		else $error("bus adv read wrong");
	mii_rd_a: assert property (
		mii_rd && mii_reg == 5'h04 |=> mii_rdata == $past(adv_word))
		else $error("mii adv read wrong");
	fixed_zero_a: assert property (
		(adv_word & 16'hf200) == 16'h0000)
		else $error("fixed adv bit set");
	strap_rst_a: assert property (
		up_reg == 3'h3
		|-> adv_word == (manual_flow_ctl_strap ? 16'h01e1 : 16'h05e1))
		else $error("adv value after reset wrong");
	// a write inside the strap window is lost by design, so skip it
	adv_wr_a: assert property (
		bus_wr && bus_addr == 9'h1d0 && !load_valid && up_reg >= 3'h3
		|=> adv_word == ($past(bus_wdata[15:0]) & 16'h0dff))
		else $error("adv write wrong");
	loader_image_a: assert property (
		load_valid |=> adv_word == ($past(load_data) & 16'h0dff))
		else $error("loader image not taken");
	lp_pause_a: assert property (
		##1 lp_pause_asym == $past(adv_word[11])
		&& lp_pause_sym == ($past(adv_word[10]) ^ $past(adv_word[11])))
		else $error("partner pause wrong");
endmodule // vphy_regs_chk

bind vphy_regs vphy_regs_chk #(.ADDR_W(ADDR_W)) u_vphy_regs_chk (
	.clk_sys(clk_sys), .rst_n(rst_n),
	.manual_flow_ctl_strap(manual_flow_ctl_strap),
	.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .mii_reg(mii_reg),
	.mii_rd(mii_rd), .mii_rdata(mii_rdata), .load_valid(load_valid),
	.load_data(load_data), .adv_word(adv_word),
	.lp_pause_sym(lp_pause_sym), .lp_pause_asym(lp_pause_asym));

// ### testbench/vphy_regs_tb.sv
// self-checking bench for the virtual phy register bank.
// assumes the checker is bound in and the host model drives mii.
`timescale 1ns/100ps
module vphy_regs_tb;
	// ----------------------------------------------
	// signals and expected state
	// ----------------------------------------------
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        strap = 1'b0;
	logic [8:0]  bus_addr = 9'h000;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [31:0] bus_wdata = 32'h0;
	logic [31:0] bus_rdata;
	logic        bus_rvalid;
	logic [4:0]  mii_reg;
	logic        mii_wr, mii_rd, mii_rvalid;
	logic [15:0] mii_wdata, mii_rdata;
	logic        load_valid = 1'b0;
	logic [15:0] load_data = 16'h0;
	logic [15:0] m [0:2];    // model: id high, id low, advert
	logic [31:0] q_bus [$];  // notes for bus reads
	logic [15:0] q_mii [$];  // notes for mii reads
	logic [31:0] d;
	int          i, n_fail = 0, n_tests = 0;
	integer      seed = 32'hfa23;
	always #2 clk_sys = ~clk_sys;
	vphy_regs #(.ADDR_W(9)) u_vphy_regs (.clk_sys(clk_sys), .rst_n(rst_n),
		.manual_flow_ctl_strap(strap), .bus_addr(bus_addr),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .mii_reg(mii_reg),
		.mii_wr(mii_wr), .mii_rd(mii_rd), .mii_wdata(mii_wdata),
		.mii_rdata(mii_rdata), .mii_rvalid(mii_rvalid),
		.load_valid(load_valid), .load_data(load_data), .adv_word(),
		.lp_pause_sym(), .lp_pause_asym());
	vphy_host u_vphy_host (.clk_sys(clk_sys), .mii_reg(mii_reg),
		.mii_wr(mii_wr), .mii_rd(mii_rd), .mii_wdata(mii_wdata));
	// fixed bits of the advertisement never take a write
	function automatic logic [15:0] wm(input int k, input logic [15:0] v);
		return (k == 2) ? (v & 16'h0dff) : v;
	endfunction
	// bus request; host idles at the same edge, read notes old value
	task automatic bus_op(input logic wr, input logic rd, input int k,
		input logic [31:0] v);
		u_vphy_host.mii_op(1'b0, 1'b0, 5'h00, 16'h0);
		{bus_wr, bus_rd, load_valid} = {wr, rd, 1'b0};
		bus_addr = 9'h1c8 + 9'(4 * k);
		if (wr && k == 2) v[4:0] = 5'h01;
		bus_wdata = v;
		if (rd) q_bus.push_back((k < 3) ? {16'h0000, m[k]} : 32'h0);
		if (wr && k < 3) m[k] = wm(k, v[15:0]);
	endtask
	// mii request; bus idles, its data line shows the inverse
	task automatic mii_do(input logic wr, input logic rd, input int k,
		input logic [15:0] v);
		u_vphy_host.mii_op(wr, rd, 5'(k + 2), v);
		{bus_wr, bus_rd, load_valid} = 3'b000;
		bus_wdata = ~bus_wdata;
		if (rd) q_mii.push_back((k < 3) ? m[k] : 16'h0000);
		if (k == 2) v[4:0] = 5'h01;
		if (wr && k < 3) m[k] = wm(k, v);
	endtask
	// loader pulse with a fresh image
	task automatic load(input logic [15:0] v);
		u_vphy_host.mii_op(1'b0, 1'b0, 5'h00, 16'h0);
		{bus_wr, bus_rd, load_valid} = 3'b001;
		load_data = v;
		m[2] = v & 16'h0dff;
	endtask
	task automatic finish_test;
		if (q_bus.size() != 0 || q_mii.size() != 0) begin
			n_fail++;
			$display("CHECK FAILED %0t read notes left unanswered", $time);
		end
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// compare each returned word with the oldest note
	always @(negedge clk_sys) begin
		if (bus_rvalid === 1'b1) begin
			n_tests++;
			if (bus_rdata !== q_bus.pop_front()) begin
				n_fail++;
				$display("CHECK FAILED %0t bus read %h", $time, bus_rdata);
			end
		end
		if (mii_rvalid === 1'b1) begin
			n_tests++;
			if (mii_rdata !== q_mii.pop_front()) begin
				n_fail++;
				$display("CHECK FAILED %0t mii read %h", $time, mii_rdata);
			end
		end
	end
	// a hang ends the run as a failure
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		$display("CHECK FAILED %0t run did not finish", $time);
		finish_test;
	end
	// two resets, strap low then high, each with reads and traffic
	initial begin
		for (int s = 0; s < 2; s++) begin
			rst_n = 1'b0;
			strap = s[0];
			repeat (6) @(posedge clk_sys);
			@(negedge clk_sys);
			rst_n = 1'b1;
			m[0] = 16'h0000;
			m[1] = 16'h0000;
			m[2] = s ? 16'h01e1 : 16'h05e1;
			repeat (4) @(negedge clk_sys);
			for (i = 0; i < 4; i++) begin
				bus_op(1'b0, 1'b1, i, 32'h0);
				mii_do(1'b0, 1'b1, i, 16'h0);
			end
			for (int n = 0; n < 40; n++) begin
				d = $random(seed);
				i = int'(d[17:16]) % 3;
				if (d[18]) bus_op(1'b1, d[20], i, d);
				else mii_do(1'b1, 1'b0, i, d[15:0]);
				bus_op(1'b0, 1'b1, i, 32'h0);
				mii_do(1'b0, 1'b1, i, 16'h0);
				if (d[19]) load(d[31:16]);
			end
			bus_op(1'b0, 1'b1, 2, 32'h0);
			bus_op(1'b0, 1'b0, 0, 32'h0);
			repeat (3) @(negedge clk_sys);
		end
		finish_test;
	end
endmodule // vphy_regs_tb
